// File: bench/sam_target_model.sv
`timescale 1ns/10ps
// Memory model standing behind the forwarded port of the decoder
module sam_target_model
   import sam_pkg::*;
#(
   parameter logic [31:0] ERR_ADDR = 32'h2000_0ff0
)
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        fwd_valid_in,
   input  wire sam_fwd_t    fwd_in,
   input  wire logic [3:0]  delay_in,
   output logic             ready_out,
   output logic [31:0]      rdata_out,
   output logic             error_out
);
   logic [31:0] mem [0:255];
   logic [31:0] waddr;
   logic [31:0] word;
   logic [3:0]  wait_cnt;
   logic [7:0]  slot;

   // Word address of the access; low word bits pick a slot, so words
   // read back must differ in those bits
   assign waddr = {fwd_in.addr[31:2], 2'h0};
   assign slot  = fwd_in.addr[9:2];

   // Model memory starts cleared
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 32'h0;
   end

   // Answers after delay_in cycles; data shows garbage when not ready
   always @(negedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ready_out <= 1'b0;
         rdata_out <= 32'h0;
         error_out <= 1'b0;
         wait_cnt  <= 4'h0;
      end
      else if (fwd_valid_in && !ready_out && wait_cnt >= delay_in)
      begin
         word = mem[slot];
         if (fwd_in.write)
            mem[slot] = (word & ~fwd_in.wmask) |
                        (fwd_in.wdata & fwd_in.wmask);
         ready_out <= 1'b1;
         rdata_out <= word;
         error_out <= (waddr == ERR_ADDR);
         wait_cnt  <= 4'h0;
      end
      else
      begin
         ready_out <= 1'b0;
         rdata_out <= ~rdata_out;
         error_out <= ~error_out;
         wait_cnt  <= (fwd_valid_in && !ready_out) ? wait_cnt + 4'h1 : 4'h0;
      end
   end
endmodule

// File: bench/tb_system_address_map_decoder.sv
`timescale 1ns/10ps
// Self-checking bench for the address map decoder
module tb_system_address_map_decoder;
   import sam_pkg::*;

   logic        clk_in;
   logic        rst_n_in;
   logic        req_valid;
   sam_req_t    req;
   logic        xf_en;
   logic        xr_en;
   logic        ddr_en;
   logic        tgt_ready;
   logic [31:0] tgt_rdata;
   logic        tgt_error;
   logic        busy;
   logic        fwd_valid;
   sam_fwd_t    fwd;
   logic        rsp_valid;
   sam_rsp_t    rsp;
   logic [3:0]  delay;
   int          fail_count;
   int          checks_done;
   logic        busy_seen;
   sam_fwd_t    fwd_seen;

   sam_decoder u_sam_decoder (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid),
      .req_in(req), .xf_en_in(xf_en), .xr_en_in(xr_en),
      .ddr_en_in(ddr_en), .tgt_ready_in(tgt_ready),
      .tgt_rdata_in(tgt_rdata), .tgt_error_in(tgt_error),
      .busy_out(busy), .fwd_valid_out(fwd_valid), .fwd_out(fwd),
      .rsp_valid_out(rsp_valid), .rsp_out(rsp));

   sam_target_model u_sam_target_model (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .fwd_valid_in(fwd_valid),
      .fwd_in(fwd), .delay_in(delay), .ready_out(tgt_ready),
      .rdata_out(tgt_rdata), .error_out(tgt_error));

   // Free-running 50 MHz clock
   initial clk_in = 1'b0;
   always #10 clk_in = ~clk_in;

   // Compares one value and counts the outcome
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then stops
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One access: returns the answer and the first forwarded target
   task automatic acc(input logic [31:0] a, input logic w,
                      input sam_size_t sz, input sam_master_t m,
                      input logic p, input logic [31:0] wd,
                      output sam_rsp_t r, output sam_target_t t);
      int n;
      t = SAM_T_NONE;
      fwd_seen = '0;
      @(negedge clk_in);
      req <= '{addr: a, write: w, size: sz, master: m, priv: p, wdata: wd};
      req_valid <= 1'b1;
      @(posedge clk_in);
      @(negedge clk_in);
      req_valid <= 1'b0;
      busy_seen = busy;
      for (n = 0; n < 60 && rsp_valid !== 1'b1; n++)
      begin
         if (fwd_valid === 1'b1 && t == SAM_T_NONE)
         begin
            t = fwd.target;
            fwd_seen = fwd;
         end
         @(posedge clk_in);
         #1;
      end
      if (n == 60)
         chk(32'h1, 32'h0);
      r = rsp;
   endtask

   // Decode check: error flag and selected target
   task automatic ck(input logic [31:0] a, input sam_master_t m,
                     input logic w, input sam_size_t sz, input logic p,
                     input logic e, input sam_target_t tg);
      sam_rsp_t    r;
      sam_target_t t;
      acc(a, w, sz, m, p, 32'h0, r, t);
      chk(r.error, e);
      chk(t, tg);
      chk(busy_seen, !e);
      chk(busy, 1'b0);
   endtask

   // Vector entry at address zero
   task automatic s_vector;
      sam_rsp_t    r;
      sam_target_t t;
      acc(32'h0, 1'b0, SAM_SZ_WORD, SAM_M_DCODE, 1'b1, 32'h0, r, t);
      chk(r.rdata, 32'h1000_0001);
      chk(r.error, 1'b0);
      ck(32'h0, SAM_M_DCODE, 1'b1, SAM_SZ_WORD, 1'b1, 1'b1, SAM_T_NONE);
   endtask

   // Fixed regions, privilege, master and size restrictions
   task automatic s_map;
      ck(32'h1000_0000, SAM_M_ICODE, 0, SAM_SZ_WORD, 1, 0, SAM_T_FLASH);
      ck(32'h102f_fffc, SAM_M_DCODE, 0, SAM_SZ_WORD, 1, 0, SAM_T_FLASH);
      ck(32'h1030_0000, SAM_M_DCODE, 0, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
      ck(32'h1000_0000, SAM_M_SYS, 0, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
      ck(32'h1080_3ffc, SAM_M_DCODE, 0, SAM_SZ_WORD, 1, 0, SAM_T_INFO);
      ck(32'h1080_0000, SAM_M_DCODE, 1, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
      ck(32'h2000_0000, SAM_M_SYS, 0, SAM_SZ_WORD, 1, 0, SAM_T_SRAM);
      ck(32'h200f_ffff, SAM_M_OTHER, 1, SAM_SZ_BYTE, 0, 0, SAM_T_SRAM);
      ck(32'h2010_0000, SAM_M_SYS, 0, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
      ck(32'h2000_0000, SAM_M_ICODE, 0, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
      ck(32'h4000_0000, SAM_M_SYS, 0, SAM_SZ_WORD, 1, 0, SAM_T_APB);
      ck(32'h400f_fffc, SAM_M_OTHER, 1, SAM_SZ_WORD, 0, 0, SAM_T_APB);
      ck(32'h4000_0001, SAM_M_SYS, 0, SAM_SZ_BYTE, 1, 1, SAM_T_NONE);
      ck(32'h4000_0002, SAM_M_SYS, 1, SAM_SZ_HALF, 1, 1, SAM_T_NONE);
      ck(32'ha000_0000, SAM_M_SYS, 0, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
      ck(32'hdfff_fffc, SAM_M_OTHER, 1, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
      ck(32'he000_0000, SAM_M_SYS, 0, SAM_SZ_WORD, 1, 0, SAM_T_PPB);
      ck(32'he000_0000, SAM_M_OTHER, 0, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
      ck(32'he00f_fffc, SAM_M_SYS, 0, SAM_SZ_WORD, 0, 1, SAM_T_NONE);
      ck(32'he010_0000, SAM_M_SYS, 0, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
      ck(32'hffff_fffc, SAM_M_SYS, 1, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
      ck(32'h2200_0000, SAM_M_OTHER, 0, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
      ck(32'h4200_0000, SAM_M_OTHER, 0, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
   endtask

   // External windows disabled, then enabled
   task automatic s_windows;
      logic        n;
      sam_target_t tf;
      sam_target_t tr;
      sam_target_t td;
      for (int en = 0; en < 2; en++)
      begin
         @(negedge clk_in);
         xf_en <= en[0];
         xr_en <= en[0];
         ddr_en <= en[0];
         n = ~en[0];
         tf = en[0] ? SAM_T_XF : SAM_T_NONE;
         tr = en[0] ? SAM_T_XR : SAM_T_NONE;
         td = en[0] ? SAM_T_DDR : SAM_T_NONE;
         ck(32'h0800_0000, SAM_M_DCODE, 0, SAM_SZ_WORD, 1, n, tf);
         ck(32'h0fff_fffc, SAM_M_ICODE, 0, SAM_SZ_WORD, 1, n, tf);
         ck(32'h0800_0000, SAM_M_DCODE, 1, SAM_SZ_WORD, 1, 1, SAM_T_NONE);
         ck(32'h6000_0000, SAM_M_SYS, 1, SAM_SZ_WORD, 1, n, td);
         ck(32'h7fff_fffc, SAM_M_SYS, 0, SAM_SZ_WORD, 1, n, td);
         ck(32'h8000_0000, SAM_M_SYS, 1, SAM_SZ_WORD, 1, n, tr);
         ck(32'h9fff_fffc, SAM_M_OTHER, 0, SAM_SZ_WORD, 1, n, tr);
      end
   endtask

   // Bit aliases over SRAM and peripherals, with a slow target
   task automatic s_bitband;
      sam_rsp_t    r;
      sam_target_t t;
      logic [31:0] al;
      delay = 4'h3;
      al = SAM_SBB_LO + (32'h11 << 5) + (32'h3 << 2);
      acc(32'h2000_0010, 1, SAM_SZ_WORD, SAM_M_SYS, 1, 32'h0, r, t);
      acc(al, 1, SAM_SZ_WORD, SAM_M_SYS, 1, 32'h1, r, t);
      chk(r.error, 1'b0);
      acc(32'h2000_0010, 0, SAM_SZ_WORD, SAM_M_SYS, 1, 32'h0, r, t);
      chk(r.rdata, 32'h0000_0800);
      acc(al, 0, SAM_SZ_WORD, SAM_M_DCODE, 1, 32'h0, r, t);
      chk(r.rdata, 32'h1);
      chk(fwd_seen.addr, 32'h2000_0010);
      chk(fwd_seen.write, 1'b0);
      acc(al + 32'h4, 0, SAM_SZ_WORD, SAM_M_SYS, 1, 32'h0, r, t);
      chk(r.rdata, 32'h0);
      acc(al, 1, SAM_SZ_WORD, SAM_M_SYS, 1, 32'h0, r, t);
      acc(32'h2000_0010, 0, SAM_SZ_WORD, SAM_M_SYS, 1, 32'h0, r, t);
      chk(r.rdata, 32'h0);
      delay = 4'h0;
      acc(32'h4000_0000, 1, SAM_SZ_WORD, SAM_M_SYS, 1, 32'h4, r, t);
      acc(SAM_PBB_LO + 32'h8, 0, SAM_SZ_WORD, SAM_M_SYS, 1, 32'h0, r, t);
      chk(r.rdata, 32'h1);
      chk(t, SAM_T_APB);
      chk(fwd_seen.addr, 32'h4000_0000);
      acc(32'h2000_0ff0, 0, SAM_SZ_WORD, SAM_M_SYS, 1, 32'h0, r, t);
      chk(r.error, 1'b1);
   endtask

   // Watchdog against a hang
   initial
   begin
      #200000;
      fail_count++;
      tally_and_finish();
   end

   // Main sequence
   initial
   begin
      fail_count = 0;
      checks_done = 0;
      rst_n_in = 1'b0;
      req_valid = 1'b0;
      req = '0;
      xf_en = 1'b1;
      xr_en = 1'b1;
      ddr_en = 1'b1;
      delay = 4'h0;
      repeat (10) @(negedge clk_in);
      rst_n_in = 1'b1;
      s_vector();
      s_map();
      s_windows();
      s_bitband();
      tally_and_finish();
   end
endmodule

// File: design/sam_decoder.sv
`timescale 1ns/10ps
// Overview of operation
// - Addresses 0 to 0x1fffffff form the code region for fetch and data.
// - Code-region data uses the data-code master, fetches the fetch master.
// - Internal flash answers fetches and data at 0x10000000..0x102fffff.
// - Address zero returns a vector entry redirecting into flash.
// - Information block up to 0x10803fff is read-only; writes fault.
// - Serial flash window, when enabled, read-only 0x08000000..0x0fffffff.
// - Serial RAM window, when enabled, ends at 0x9fffffff.
// - DDR memory window, when enabled, 0x60000000..0x7fffffff.
// - System SRAM answers at 0x20000000..0x200fffff.
// - SRAM fetches go over the system master, bypassing any cache.
// - Core SRAM alias words read or set or clear one SRAM bit.
// - Alias writes are read-modify-write; non-core alias access faults.
// - Core peripheral alias 0x42000000..0x43ffffff reaches bits of peripherals.
// - Non-core access to peripheral alias gets a bus error.
// - 0x40000000..0x400fffff forwards through the peripheral bridge.
// - Bridged region accepts only aligned word transfers; others fault.
// - 0xa0000000..0xdfffffff is unimplemented.
// - Core-private region accepts only the core, refusing other masters.
// - Core-private region needs privileged mode.
// - 0xe0100000 upward is unimplemented.
module sam_decoder
   import sam_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        req_valid_in,
   input  wire sam_req_t    req_in,
   input  wire logic        xf_en_in,
   input  wire logic        xr_en_in,
   input  wire logic        ddr_en_in,
   input  wire logic        tgt_ready_in,
   input  wire logic [31:0] tgt_rdata_in,
   input  wire logic        tgt_error_in,
   output logic             busy_out,
   output logic             fwd_valid_out,
   output sam_fwd_t         fwd_out,
   output logic             rsp_valid_out,
   output sam_rsp_t         rsp_out
);

   typedef enum logic [2:0] {
      SAM_S_IDLE,
      SAM_S_ACCESS,
      SAM_S_RMW_RD,
      SAM_S_RMW_WR
   } sam_state_t;

   sam_state_t       state;
   sam_state_t       next_state;
   sam_target_t      dec_target;
   logic             dec_alias;
   logic             dec_error;
   sam_req_t         held;
   logic [4:0]       bit_pos;

   // Per-address classification
   sam_region_check u_check
   (
      .req_in     (req_in),
      .xf_en_in   (xf_en_in),
      .xr_en_in   (xr_en_in),
      .ddr_en_in  (ddr_en_in),
      .target_out (dec_target),
      .alias_out  (dec_alias),
      .error_out  (dec_error)
   );

   // Alias translation: byte offset from bits 24:5, bit from bits 4:2
   wire logic [19:0] bb_byte = req_in.addr[SAM_BB_BYTE_MSB:SAM_BB_BYTE_LSB];
   wire logic [2:0]  bb_bit  = req_in.addr[SAM_BB_BIT_MSB:SAM_BB_BIT_LSB];
   wire logic        bb_peri = req_in.addr >= SAM_PBB_LO;
   wire logic [31:0] bb_base = bb_peri ? SAM_APB_LO : SAM_SRAM_LO;
   wire logic [31:0] bb_addr = bb_base | {12'h000, bb_byte};
   wire logic [31:0] bb_word = bb_addr & SAM_WORD_MASK;
   wire logic [4:0]  bb_pos  = {bb_addr[1:0], bb_bit};
   wire sam_target_t bb_tgt  = bb_peri ? SAM_T_APB : SAM_T_SRAM;

   wire logic accept   = req_valid_in && (state == SAM_S_IDLE);
   wire logic tgt_done = tgt_ready_in;
   wire logic [31:0] one_hot = 32'h0000_0001 << bit_pos;
   // Merge of the target word with the alias bit for the write-back
   wire logic [31:0] rmw_data = held.wdata[0] ?
                                (tgt_rdata_in | one_hot) :
                                (tgt_rdata_in & ~one_hot);
   wire logic [31:0] bit_read = {31'h0, tgt_rdata_in[bit_pos]};

   // State sequencing
   always_comb
   begin
      next_state = state;
      case (state)
         SAM_S_IDLE:
            if (accept && !dec_error && dec_target != SAM_T_VEC)
               next_state = dec_alias ? SAM_S_RMW_RD : SAM_S_ACCESS;
         SAM_S_ACCESS:
            if (tgt_done)
               next_state = SAM_S_IDLE;
         SAM_S_RMW_RD:
            if (tgt_done)
               next_state = (held.write && !tgt_error_in) ?
                            SAM_S_RMW_WR : SAM_S_IDLE;
         SAM_S_RMW_WR:
            if (tgt_done)
               next_state = SAM_S_IDLE;
         default:
            next_state = SAM_S_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         state <= SAM_S_IDLE;
      else
         state <= next_state;
   end

   // Latch the request and alias bit position
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         held    <= '0;
         bit_pos <= 5'h00;
      end
      else if (accept)
      begin
         held    <= req_in;
         bit_pos <= bb_pos;
      end
   end

   // Forward port towards the selected target
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         fwd_valid_out <= 1'b0;
         fwd_out       <= '0;
      end
      else if (accept && !dec_error && dec_target != SAM_T_VEC)
      begin
         fwd_valid_out <= 1'b1;
         if (dec_alias)
         begin
            fwd_out.target <= bb_tgt;
            fwd_out.addr   <= bb_word;
            fwd_out.write  <= 1'b0;
            fwd_out.size   <= SAM_SZ_WORD;
            fwd_out.wdata  <= '0;
            fwd_out.wmask  <= '0;
         end
         else
         begin
            // SRAM fetches go straight to SRAM, no cache path
            fwd_out.target <= dec_target;
            fwd_out.addr   <= req_in.addr;
            fwd_out.write  <= req_in.write;
            fwd_out.size   <= req_in.size;
            fwd_out.wdata  <= req_in.wdata;
            fwd_out.wmask  <= '1;
         end
      end
      else if (state == SAM_S_RMW_RD && tgt_done && held.write &&
               !tgt_error_in)
      begin
         fwd_valid_out  <= 1'b1;
         fwd_out.write  <= 1'b1;
         fwd_out.wdata  <= rmw_data;
         fwd_out.wmask  <= one_hot;
      end
      else if (tgt_done)
         fwd_valid_out <= 1'b0;
   end

   // Answer to the master
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rsp_valid_out <= 1'b0;
         rsp_out       <= '0;
      end
      else if (accept && (dec_error || dec_target == SAM_T_VEC))
      begin
         rsp_valid_out <= 1'b1;
         rsp_out.error <= dec_error;
         rsp_out.rdata <= dec_error ? 32'h0000_0000 :
                          SAM_RESET_VEC;
      end
      else if (state == SAM_S_ACCESS && tgt_done)
      begin
         rsp_valid_out <= 1'b1;
         rsp_out.error <= tgt_error_in;
         rsp_out.rdata <= tgt_rdata_in;
      end
      else if (state == SAM_S_RMW_RD && tgt_done &&
               (!held.write || tgt_error_in))
      begin
         rsp_valid_out <= 1'b1;
         rsp_out.error <= tgt_error_in;
         rsp_out.rdata <= bit_read;
      end
      else if (state == SAM_S_RMW_WR && tgt_done)
      begin
         rsp_valid_out <= 1'b1;
         rsp_out.error <= tgt_error_in;
         rsp_out.rdata <= 32'h0000_0000;
      end
      else
         rsp_valid_out <= 1'b0;
   end

   // Busy while a forwarded access is outstanding
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         busy_out <= 1'b0;
      else
         busy_out <= next_state != SAM_S_IDLE;
   end

   // Assertions
   a_err_one_cycle: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && dec_error |=> rsp_valid_out && rsp_out.error)
      else $error("fault not answered next cycle");
   a_ppb_other_err: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && dec_target == SAM_T_PPB && req_in.master == SAM_M_OTHER
      |=> rsp_out.error && !fwd_valid_out)
      else $error("non-core reached private region");
   a_ppb_user_err: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && dec_target == SAM_T_PPB && !req_in.priv
      |=> rsp_out.error)
      else $error("user mode reached private region");
   a_apb_byte_err: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && dec_target == SAM_T_APB && req_in.size != SAM_SZ_WORD
      |=> rsp_valid_out && rsp_out.error)
      else $error("narrow bridge access not faulted");
   a_alias_noncore: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && req_in.master == SAM_M_OTHER &&
      req_in.addr >= SAM_SBB_LO && req_in.addr <= SAM_SBB_HI
      |=> rsp_out.error && !fwd_valid_out)
      else $error("non-core alias not faulted");
   a_vec_redirect: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && req_in.addr == SAM_CODE_LO && !req_in.write &&
      req_in.master != SAM_M_SYS
      |=> rsp_valid_out && rsp_out.rdata == SAM_RESET_VEC)
      else $error("reset vector wrong");
   a_info_ro: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && dec_target == SAM_T_INFO && req_in.write
      |=> rsp_out.error)
      else $error("info block write accepted");
   a_sram_fwd: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && !dec_error && dec_target == SAM_T_SRAM && !dec_alias
      |=> fwd_valid_out && fwd_out.target == SAM_T_SRAM &&
      fwd_out.addr == $past(req_in.addr))
      else $error("sram access misrouted");
   a_extdev_err: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && req_in.addr >= SAM_EXTDEV_LO &&
      req_in.addr <= SAM_EXTDEV_HI |=> rsp_out.error)
      else $error("external device space answered");
   a_vendor_err: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && req_in.addr >= SAM_VEND_LO |=> rsp_out.error)
      else $error("vendor space answered");
   a_xf_disabled: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && !xf_en_in && req_in.addr >= SAM_XF_LO &&
      req_in.addr <= SAM_XF_HI |=> rsp_out.error)
      else $error("disabled flash window answered");
   a_rmw_write: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      state == SAM_S_RMW_RD && tgt_done && held.write && !tgt_error_in
      |=> fwd_valid_out && fwd_out.write && $onehot(fwd_out.wmask))
      else $error("alias write not merged");
   a_code_sys_err: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && req_in.addr <= SAM_CODE_HI && req_in.master == SAM_M_SYS
      |=> rsp_valid_out && rsp_out.error && !fwd_valid_out)
      else $error("system master reached code region");
   a_flash_fwd: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && req_in.addr >= SAM_FLASH_LO && req_in.addr <= SAM_FLASH_HI
      && !req_in.write && req_in.master != SAM_M_SYS
      |=> fwd_valid_out && fwd_out.target == SAM_T_FLASH)
      else $error("flash read not forwarded");
   a_pbb_noncore: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && req_in.master == SAM_M_OTHER &&
      req_in.addr >= SAM_PBB_LO && req_in.addr <= SAM_PBB_HI
      |=> rsp_out.error && !fwd_valid_out)
      else $error("non-core peripheral alias not faulted");
   a_sram_fetch: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && dec_target == SAM_T_SRAM && req_in.master == SAM_M_ICODE
      |=> rsp_out.error && !fwd_valid_out)
      else $error("sram fetch on code master");
   a_ddr_disabled: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && !ddr_en_in && req_in.addr >= SAM_DDR_LO &&
      req_in.addr <= SAM_DDR_HI |=> rsp_out.error)
      else $error("disabled ddr window answered");
   a_xr_disabled: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      accept && !xr_en_in && req_in.addr >= SAM_XR_LO &&
      req_in.addr <= SAM_XR_HI |=> rsp_out.error)
      else $error("disabled ram window answered");

endmodule

// File: design/sam_pkg.sv
package sam_pkg;

   // Address map bounds
   localparam logic [31:0] SAM_CODE_LO     = 32'h0000_0000;
   localparam logic [31:0] SAM_CODE_HI     = 32'h1fff_ffff;
   localparam logic [31:0] SAM_VEC_HI      = 32'h0000_0003;
   localparam logic [31:0] SAM_XF_LO       = 32'h0800_0000;
   localparam logic [31:0] SAM_XF_HI       = 32'h0fff_ffff;
   localparam logic [31:0] SAM_FLASH_LO    = 32'h1000_0000;
   localparam logic [31:0] SAM_FLASH_HI    = 32'h102f_ffff;
   localparam logic [31:0] SAM_INFO_LO     = 32'h1080_0000;
   localparam logic [31:0] SAM_INFO_HI     = 32'h1080_3fff;
   localparam logic [31:0] SAM_SRAM_LO     = 32'h2000_0000;
   localparam logic [31:0] SAM_SRAM_HI     = 32'h200f_ffff;
   localparam logic [31:0] SAM_SBB_LO      = 32'h2200_0000;
   localparam logic [31:0] SAM_SBB_HI      = 32'h23ff_ffff;
   localparam logic [31:0] SAM_APB_LO      = 32'h4000_0000;
   localparam logic [31:0] SAM_APB_HI      = 32'h400f_ffff;
   localparam logic [31:0] SAM_PBB_LO      = 32'h4200_0000;
   localparam logic [31:0] SAM_PBB_HI      = 32'h43ff_ffff;
   localparam logic [31:0] SAM_DDR_LO      = 32'h6000_0000;
   localparam logic [31:0] SAM_DDR_HI      = 32'h7fff_ffff;
   localparam logic [31:0] SAM_XR_LO       = 32'h8000_0000;
   localparam logic [31:0] SAM_XR_HI       = 32'h9fff_ffff;
   localparam logic [31:0] SAM_EXTDEV_LO   = 32'ha000_0000;
   localparam logic [31:0] SAM_EXTDEV_HI   = 32'hdfff_ffff;
   localparam logic [31:0] SAM_PPB_LO      = 32'he000_0000;
   localparam logic [31:0] SAM_PPB_HI      = 32'he00f_ffff;
   localparam logic [31:0] SAM_VEND_LO     = 32'he010_0000;

   // Alias field positions: word index picks bit, byte offset picks byte
   localparam int SAM_BB_BIT_LSB  = 2;
   localparam int SAM_BB_BIT_MSB  = 4;
   localparam int SAM_BB_BYTE_LSB = 5;
   localparam int SAM_BB_BYTE_MSB = 24;
   localparam logic [31:0] SAM_WORD_MASK = 32'hffff_fffc;
   localparam logic [1:0]  SAM_ALIGN_ZERO = 2'h0;

   // Reset vector entry: points into flash (thumb bit set)
   localparam logic [31:0] SAM_RESET_VEC = 32'h1000_0001;

   // Transfer sizes
   typedef enum logic [1:0] {
      SAM_SZ_BYTE = 2'h0,
      SAM_SZ_HALF = 2'h1,
      SAM_SZ_WORD = 2'h2
   } sam_size_t;

   // Requesting master
   typedef enum logic [1:0] {
      SAM_M_ICODE,
      SAM_M_DCODE,
      SAM_M_SYS,
      SAM_M_OTHER
   } sam_master_t;

   // Target selected by the decoder
   typedef enum logic [3:0] {
      SAM_T_NONE,
      SAM_T_VEC,
      SAM_T_FLASH,
      SAM_T_INFO,
      SAM_T_XF,
      SAM_T_SRAM,
      SAM_T_APB,
      SAM_T_DDR,
      SAM_T_XR,
      SAM_T_PPB
   } sam_target_t;

   // Incoming access
   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      sam_size_t   size;
      sam_master_t master;
      logic        priv;
      logic [31:0] wdata;
   } sam_req_t;

   // Access forwarded to one target
   typedef struct packed {
      sam_target_t target;
      logic [31:0] addr;
      logic        write;
      sam_size_t   size;
      logic [31:0] wdata;
      logic [31:0] wmask;
   } sam_fwd_t;

   // Answer to the master
   typedef struct packed {
      logic        error;
      logic [31:0] rdata;
   } sam_rsp_t;

endpackage

// File: design/sam_region_check.sv
`timescale 1ns/10ps
// Classifies one address into a target and an error flag
module sam_region_check
   import sam_pkg::*;
(
   input  wire sam_req_t    req_in,
   input  wire logic        xf_en_in,
   input  wire logic        xr_en_in,
   input  wire logic        ddr_en_in,
   output sam_target_t      target_out,
   output logic             alias_out,
   output logic             error_out
);

   function automatic logic in_rng(input logic [31:0] a,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   wire logic [31:0] a        = req_in.addr;
   wire logic        is_core  = req_in.master != SAM_M_OTHER;
   wire logic        is_fetch = req_in.master == SAM_M_ICODE;
   wire logic        is_code  = in_rng(a, SAM_CODE_LO, SAM_CODE_HI);
   wire logic        is_alias = in_rng(a, SAM_SBB_LO, SAM_SBB_HI) ||
                                in_rng(a, SAM_PBB_LO, SAM_PBB_HI);
   wire logic        bad_word = (req_in.size != SAM_SZ_WORD) ||
                                (a[1:0] != SAM_ALIGN_ZERO);
   sam_target_t      t;

   // Region decode, first match wins
   always_comb
   begin
      t = SAM_T_NONE;
      if (in_rng(a, SAM_CODE_LO, SAM_VEC_HI))
         t = SAM_T_VEC;
      else if (xf_en_in && in_rng(a, SAM_XF_LO, SAM_XF_HI))
         t = SAM_T_XF;
      else if (in_rng(a, SAM_FLASH_LO, SAM_FLASH_HI))
         t = SAM_T_FLASH;
      else if (in_rng(a, SAM_INFO_LO, SAM_INFO_HI))
         t = SAM_T_INFO;
      else if (in_rng(a, SAM_SRAM_LO, SAM_SRAM_HI))
         t = SAM_T_SRAM;
      else if (in_rng(a, SAM_APB_LO, SAM_APB_HI))
         t = SAM_T_APB;
      else if (ddr_en_in && in_rng(a, SAM_DDR_LO, SAM_DDR_HI))
         t = SAM_T_DDR;
      else if (xr_en_in && in_rng(a, SAM_XR_LO, SAM_XR_HI))
         t = SAM_T_XR;
      else if (in_rng(a, SAM_PPB_LO, SAM_PPB_HI))
         t = SAM_T_PPB;
   end

   // Code region travels on code masters, rest on system master
   wire logic bus_bad = is_code ? (req_in.master == SAM_M_SYS)
                        : (req_in.master == SAM_M_ICODE ||
                           req_in.master == SAM_M_DCODE);
   // Read-only targets refuse writes
   wire logic ro_bad  = req_in.write && (t == SAM_T_INFO ||
                        t == SAM_T_XF || t == SAM_T_VEC ||
                        t == SAM_T_FLASH);
   // Fetch only from code outside the info block, SRAM or external memories
   wire logic fx_bad  = is_fetch && (t == SAM_T_APB ||
                        t == SAM_T_PPB || t == SAM_T_INFO);
   wire logic apb_bad = (t == SAM_T_APB) && bad_word;
   wire logic ppb_bad = (t == SAM_T_PPB) &&
                        (!is_core || !req_in.priv);
   wire logic al_ok   = is_alias && is_core && !is_fetch &&
                        !bad_word;

   assign alias_out  = al_ok;
   assign target_out = t;
   // Unmapped, disabled, vendor and external-device space all fault
   assign error_out  = is_alias ? !al_ok
                       : ((t == SAM_T_NONE) || bus_bad || ro_bad ||
                          fx_bad || apb_bad || ppb_bad);

endmodule
